// File: inc/lvmix_pkg.sv
// Shared constants and types for the layered video mixer
package lvmix_pkg;

    // ------------------------------------------------------------
    // Stream geometry
    // ------------------------------------------------------------
    localparam int LAYERS  = 3;
    localparam int CHANS   = 3;
    localparam int CHAN_W  = 8;
    localparam int DATA_W  = CHANS * CHAN_W;
    localparam int ALPHA_W = 8;
    localparam int PAY_W   = DATA_W + 2;

    // Build-time option: alpha streams and blending
    localparam bit ALPHA_EN_DEF = 1'b1;

    // ------------------------------------------------------------
    // Control slave map (word offsets)
    // ------------------------------------------------------------
    localparam int OFS_W  = 4;
    localparam int CTRL_W = 32;
    localparam int CNT_W  = 16;

    localparam logic [OFS_W-1:0] OFS_CONTROL   = 4'h0;
    localparam logic [OFS_W-1:0] OFS_STATUS    = 4'h1;
    localparam logic [OFS_W-1:0] OFS_LAYER_EN  = 4'h2;
    localparam logic [OFS_W-1:0] OFS_PKT_COUNT = 4'h3;
    localparam logic [OFS_W-1:0] OFS_IDENT     = 4'h4;

    localparam int CTRL_GO_BIT    = 0;
    localparam int STATUS_RUN_BIT = 0;

    localparam logic [LAYERS-1:0] LAYER_EN_RST = 3'h7;
    localparam logic [CTRL_W-1:0] RD_ZERO      = 32'h0000_0000;
    // Arbitrary value, not tied to any maker
    localparam logic [CTRL_W-1:0] IDENT_VALUE  = 32'h0000_1234;

    localparam logic [ALPHA_W-1:0] ALPHA_FULL  = 8'hFF;

    // ------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        st_idle = 2'b01,
        st_run  = 2'b10
    } lvmix_state_e;

endpackage

// File: rtl/lvmix_skid.sv
// Two-entry output buffer with registered outputs
`timescale 1ns/1ps
module lvmix_skid (
    // Clock and reset
    input  wire logic                          clk,
    input  wire logic                          nrst,
    // Filling side
    input  wire logic [lvmix_pkg::PAY_W-1:0]   in_data,
    input  wire logic                          in_valid,
    output logic                               in_ready,
    // Draining side
    output logic      [lvmix_pkg::PAY_W-1:0]   out_data,
    output logic                               out_valid,
    input  wire logic                          out_ready
);

    logic [lvmix_pkg::PAY_W-1:0] head_ff, nxt_head;
    logic [lvmix_pkg::PAY_W-1:0] spare_ff, nxt_spare;
    logic                        head_v_ff, nxt_head_v;
    logic                        spare_v_ff, nxt_spare_v;
    logic                        push;
    logic                        pop;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        push        = in_valid && !spare_v_ff;
        pop         = head_v_ff && out_ready;
        nxt_head    = head_ff;
        nxt_head_v  = head_v_ff;
        nxt_spare   = spare_ff;
        nxt_spare_v = spare_v_ff;
        if (pop) begin
            if (spare_v_ff) begin
                nxt_head    = spare_ff;
                nxt_spare_v = 1'b0;
            end else if (push) begin
                nxt_head    = in_data;
            end else begin
                nxt_head_v  = 1'b0;
            end
        end else if (push) begin
            if (head_v_ff) begin
                nxt_spare   = in_data;
                nxt_spare_v = 1'b1;
            end else begin
                nxt_head    = in_data;
                nxt_head_v  = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            head_ff    <= '0;
            spare_ff   <= '0;
            head_v_ff  <= 1'b0;
            spare_v_ff <= 1'b0;
        end else begin
            head_ff    <= nxt_head;
            spare_ff   <= nxt_spare;
            head_v_ff  <= nxt_head_v;
            spare_v_ff <= nxt_spare_v;
        end
    end

    assign in_ready  = !spare_v_ff;
    assign out_data  = head_ff;
    assign out_valid = head_v_ff;

endmodule

// File: rtl/lvmix_top.sv
// Layered video mixer: per-layer stream inputs, blended output, control slave
`timescale 1ns/1ps
module lvmix_top #(
    parameter bit ALPHA_EN = lvmix_pkg::ALPHA_EN_DEF
) (
    // Clock and reset
    input  wire logic                           clk,
    input  wire logic                           nrst,
    // Layer pixel inputs
    input  wire logic [lvmix_pkg::DATA_W-1:0]   din_data   [lvmix_pkg::LAYERS],
    input  wire logic [lvmix_pkg::LAYERS-1:0]   din_valid,
    output logic      [lvmix_pkg::LAYERS-1:0]   din_ready,
    input  wire logic [lvmix_pkg::LAYERS-1:0]   din_sop,
    input  wire logic [lvmix_pkg::LAYERS-1:0]   din_eop,
    // Layer alpha inputs
    input  wire logic [lvmix_pkg::ALPHA_W-1:0]  alpha_data [lvmix_pkg::LAYERS],
    input  wire logic [lvmix_pkg::LAYERS-1:0]   alpha_valid,
    output logic      [lvmix_pkg::LAYERS-1:0]   alpha_ready,
    input  wire logic [lvmix_pkg::LAYERS-1:0]   alpha_sop,
    input  wire logic [lvmix_pkg::LAYERS-1:0]   alpha_eop,
    // Mixed output stream
    output logic      [lvmix_pkg::DATA_W-1:0]   dout_data,
    output logic                                dout_valid,
    input  wire logic                           dout_ready,
    output logic                                dout_sop,
    output logic                                dout_eop,
    // Control slave
    input  wire logic                           ctrl_select,
    input  wire logic [lvmix_pkg::OFS_W-1:0]    ctrl_word_offset,
    input  wire logic                           ctrl_wr_strobe,
    input  wire logic [lvmix_pkg::CTRL_W-1:0]   ctrl_wr_word,
    output logic      [lvmix_pkg::CTRL_W-1:0]   ctrl_rd_word
);

    localparam int L = lvmix_pkg::LAYERS;

    // ------------------------------------------------------------
    // Blend of one layer over the running result
    // ------------------------------------------------------------
    function automatic logic [lvmix_pkg::DATA_W-1:0] blend(
        input logic [lvmix_pkg::DATA_W-1:0]  base,
        input logic [lvmix_pkg::DATA_W-1:0]  top,
        input logic [lvmix_pkg::ALPHA_W-1:0] a
    );
        logic [lvmix_pkg::DATA_W-1:0] res;
        logic [2*lvmix_pkg::CHAN_W:0] sum;
        res = '0;
        sum = '0;
        for (int c = 0; c < lvmix_pkg::CHANS; c++) begin
            sum = (2*lvmix_pkg::CHAN_W+1)'(a * top[c*lvmix_pkg::CHAN_W +: lvmix_pkg::CHAN_W])
                + (2*lvmix_pkg::CHAN_W+1)'((lvmix_pkg::ALPHA_FULL - a)
                * base[c*lvmix_pkg::CHAN_W +: lvmix_pkg::CHAN_W]);
            res[c*lvmix_pkg::CHAN_W +: lvmix_pkg::CHAN_W] = sum[2*lvmix_pkg::CHAN_W-1:lvmix_pkg::CHAN_W];
        end
        return res;
    endfunction

    // ------------------------------------------------------------
    // Per-layer holding registers
    // ------------------------------------------------------------
    // Each layer is caught in its own register, so a word taken on one
    // input never waits on the others' valid; costs one idle cycle per word.
    logic [lvmix_pkg::DATA_W-1:0]  hold_d_ff  [L];
    logic [lvmix_pkg::DATA_W-1:0]  nxt_hold_d [L];
    logic [lvmix_pkg::ALPHA_W-1:0] hold_a_ff  [L];
    logic [lvmix_pkg::ALPHA_W-1:0] nxt_hold_a [L];
    logic [L-1:0]                  hold_v_ff, nxt_hold_v;
    logic [L-1:0]                  hold_av_ff, nxt_hold_av;
    logic                          hold_sop_ff, nxt_hold_sop;
    logic                          hold_eop_ff, nxt_hold_eop;
    logic [L-1:0]                  din_ready_ff, nxt_din_ready;
    logic [L-1:0]                  alpha_ready_ff, nxt_alpha_ready;

    // Sequencer and control state
    lvmix_pkg::lvmix_state_e       state_ff, nxt_state;
    logic                          go_ff, nxt_go;
    logic [L-1:0]                  layer_en_ff, nxt_layer_en;
    logic [lvmix_pkg::CNT_W-1:0]   pkt_count_ff, nxt_pkt_count;
    logic [lvmix_pkg::CTRL_W-1:0]  rd_word_ff, nxt_rd_word;

    // Mixing datapath
    logic                          all_full;
    logic                          fire;
    logic                          buf_push;
    logic                          buf_ready;
    logic [lvmix_pkg::DATA_W-1:0]  mix;
    logic [lvmix_pkg::PAY_W-1:0]   buf_out;

    // ------------------------------------------------------------
    // Mixing and sequencing
    // ------------------------------------------------------------
    always_comb begin
        all_full = hold_v_ff[0];
        for (int i = 1; i < L; i++) begin
            all_full = all_full && hold_v_ff[i] && (!ALPHA_EN || hold_av_ff[i]);
        end
        // Idle and stopped: inputs stall rather than drain
        fire = all_full && buf_ready && (state_ff == lvmix_pkg::st_run || go_ff);
        mix  = hold_d_ff[0];
        for (int i = 1; i < L; i++) begin
            if (layer_en_ff[i]) begin
                mix = ALPHA_EN ? blend(mix, hold_d_ff[i], hold_a_ff[i]) : hold_d_ff[i];
            end
        end
        buf_push      = 1'b0;
        nxt_state     = state_ff;
        nxt_pkt_count = pkt_count_ff;
        case (state_ff)
            lvmix_pkg::st_idle: begin
                // Words before a start marker are dropped to resynchronise
                if (fire && hold_sop_ff) begin
                    buf_push  = 1'b1;
                    nxt_state = hold_eop_ff ? lvmix_pkg::st_idle : lvmix_pkg::st_run;
                end
            end
            lvmix_pkg::st_run: begin
                if (fire) begin
                    buf_push = 1'b1;
                    if (hold_eop_ff) begin
                        nxt_state = lvmix_pkg::st_idle;
                    end
                end
            end
            default: nxt_state = lvmix_pkg::st_idle;
        endcase
        if (buf_push && hold_eop_ff) begin
            nxt_pkt_count = pkt_count_ff + 1'b1;
        end
    end

    always_comb begin
        nxt_hold_d      = hold_d_ff;
        nxt_hold_a      = hold_a_ff;
        nxt_hold_v      = hold_v_ff;
        nxt_hold_av     = hold_av_ff;
        nxt_hold_sop    = hold_sop_ff;
        nxt_hold_eop    = hold_eop_ff;
        nxt_alpha_ready = '0;
        for (int i = 0; i < L; i++) begin
            if (fire) begin
                nxt_hold_v[i]  = 1'b0;
                nxt_hold_av[i] = 1'b0;
            end
            if (din_valid[i] && din_ready_ff[i]) begin
                nxt_hold_d[i] = din_data[i];
                nxt_hold_v[i] = 1'b1;
                if (i == 0) begin
                    nxt_hold_sop = din_sop[0];
                    nxt_hold_eop = din_eop[0];
                end
            end
            if (i > 0 && ALPHA_EN && alpha_valid[i] && alpha_ready_ff[i]) begin
                nxt_hold_a[i]  = alpha_data[i];
                nxt_hold_av[i] = 1'b1;
            end
        end
        nxt_din_ready = ~nxt_hold_v;
        for (int i = 1; i < L; i++) begin
            nxt_alpha_ready[i] = ALPHA_EN && !nxt_hold_av[i];
        end
        // Background alpha is taken and thrown away
        nxt_alpha_ready[0] = ALPHA_EN;
    end

    // ------------------------------------------------------------
    // Control slave
    // ------------------------------------------------------------
    always_comb begin
        nxt_go       = go_ff;
        nxt_layer_en = layer_en_ff;
        nxt_rd_word  = rd_word_ff;
        if (ctrl_select) begin
            if (ctrl_wr_strobe) begin
                case (ctrl_word_offset)
                    lvmix_pkg::OFS_CONTROL:  nxt_go       = ctrl_wr_word[lvmix_pkg::CTRL_GO_BIT];
                    lvmix_pkg::OFS_LAYER_EN: nxt_layer_en = ctrl_wr_word[L-1:0];
                    default:                 nxt_go       = go_ff;
                endcase
            end else begin
                nxt_rd_word = lvmix_pkg::RD_ZERO;
                case (ctrl_word_offset)
                    lvmix_pkg::OFS_CONTROL:   nxt_rd_word[lvmix_pkg::CTRL_GO_BIT] = go_ff;
                    lvmix_pkg::OFS_STATUS:    nxt_rd_word[lvmix_pkg::STATUS_RUN_BIT] =
                                                  (state_ff == lvmix_pkg::st_run);
                    lvmix_pkg::OFS_LAYER_EN:  nxt_rd_word[L-1:0] = layer_en_ff;
                    lvmix_pkg::OFS_PKT_COUNT: nxt_rd_word[lvmix_pkg::CNT_W-1:0] = pkt_count_ff;
                    lvmix_pkg::OFS_IDENT:     nxt_rd_word = lvmix_pkg::IDENT_VALUE;
                    default:                  nxt_rd_word = lvmix_pkg::RD_ZERO;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < L; i++) begin
                hold_d_ff[i] <= '0;
                hold_a_ff[i] <= '0;
            end
            hold_v_ff      <= '0;
            hold_av_ff     <= '0;
            hold_sop_ff    <= 1'b0;
            hold_eop_ff    <= 1'b0;
            din_ready_ff   <= '0;
            alpha_ready_ff <= '0;
            state_ff       <= lvmix_pkg::st_idle;
            go_ff          <= 1'b0;
            layer_en_ff    <= lvmix_pkg::LAYER_EN_RST;
            pkt_count_ff   <= '0;
            rd_word_ff     <= lvmix_pkg::RD_ZERO;
        end else begin
            hold_d_ff      <= nxt_hold_d;
            hold_a_ff      <= nxt_hold_a;
            hold_v_ff      <= nxt_hold_v;
            hold_av_ff     <= nxt_hold_av;
            hold_sop_ff    <= nxt_hold_sop;
            hold_eop_ff    <= nxt_hold_eop;
            din_ready_ff   <= nxt_din_ready;
            alpha_ready_ff <= nxt_alpha_ready;
            state_ff       <= nxt_state;
            go_ff          <= nxt_go;
            layer_en_ff    <= nxt_layer_en;
            pkt_count_ff   <= nxt_pkt_count;
            rd_word_ff     <= nxt_rd_word;
        end
    end

    // ------------------------------------------------------------
    // Output buffer
    // ------------------------------------------------------------
    lvmix_skid u_skid (
        .clk       (clk),
        .nrst      (nrst),
        .in_data   ({hold_sop_ff && state_ff == lvmix_pkg::st_idle, hold_eop_ff, mix}),
        .in_valid  (buf_push),
        .in_ready  (buf_ready),
        .out_data  (buf_out),
        .out_valid (dout_valid),
        .out_ready (dout_ready)
    );

    assign dout_data    = buf_out[lvmix_pkg::DATA_W-1:0];
    assign dout_eop     = buf_out[lvmix_pkg::DATA_W];
    assign dout_sop     = buf_out[lvmix_pkg::DATA_W+1];
    assign din_ready    = din_ready_ff;
    assign alpha_ready  = alpha_ready_ff;
    assign ctrl_rd_word = rd_word_ff;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    property p_reset_state;
        $rose(nrst) |-> state_ff == lvmix_pkg::st_idle && !dout_valid && din_ready == '0;
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("not idle after reset");

    property p_ready_full;
        hold_v_ff[0] && !fire |=> !din_ready[0];
    endproperty
    a_ready_full: assert property (p_ready_full) else $error("ready while holding");

    property p_take;
        din_valid[1] && din_ready[1] |=> hold_v_ff[1] && hold_d_ff[1] == $past(din_data[1]);
    endproperty
    a_take: assert property (p_take) else $error("word not captured");

    property p_out_hold;
        dout_valid && !dout_ready |=> dout_valid && $stable(dout_data) && $stable(dout_eop);
    endproperty
    a_out_hold: assert property (p_out_hold) else $error("output dropped under stall");

    property p_sop_first;
        state_ff == lvmix_pkg::st_idle && buf_push |-> hold_sop_ff;
    endproperty
    a_sop_first: assert property (p_sop_first) else $error("packet started without sop");

    property p_eop_end;
        buf_push && hold_eop_ff |=> state_ff == lvmix_pkg::st_idle;
    endproperty
    a_eop_end: assert property (p_eop_end) else $error("eop did not end packet");

    property p_no_select;
        !ctrl_select |=> $stable(go_ff) && $stable(layer_en_ff) && $stable(ctrl_rd_word);
    endproperty
    a_no_select: assert property (p_no_select) else $error("unselected access acted");

    property p_write;
        ctrl_select && ctrl_wr_strobe && ctrl_word_offset == lvmix_pkg::OFS_LAYER_EN
            |=> layer_en_ff == $past(ctrl_wr_word[L-1:0]);
    endproperty
    a_write: assert property (p_write) else $error("write not captured");

    property p_read;
        ctrl_select && !ctrl_wr_strobe && ctrl_word_offset == lvmix_pkg::OFS_CONTROL
            |=> ctrl_rd_word[lvmix_pkg::CTRL_GO_BIT] == $past(go_ff);
    endproperty
    a_read: assert property (p_read) else $error("read data wrong");

    property p_bg_alpha;
        $past(nrst) |-> alpha_ready[0] == ALPHA_EN;
    endproperty
    a_bg_alpha: assert property (p_bg_alpha) else $error("background alpha not ignored");

    c_packet: cover property (buf_push && hold_sop_ff ##[1:40] buf_push && hold_eop_ff);
    c_stall:  cover property ((dout_valid && !dout_ready) [*3]);
    c_full:   cover property (!buf_ready && fire == 1'b0 && all_full);
    c_read:   cover property (ctrl_select && !ctrl_wr_strobe && ctrl_word_offset == lvmix_pkg::OFS_PKT_COUNT);

endmodule

// File: sim/lvmix_sink_model.sv
// Downstream consumer model for the mixer output stream
`timescale 1ns/1ps
module lvmix_sink_model (
    // Clock and reset
    input  wire logic                         clk,
    input  wire logic                         nrst,
    // Mixed stream from the mixer
    input  wire logic [lvmix_pkg::DATA_W-1:0] dout_data,
    input  wire logic                         dout_valid,
    input  wire logic                         dout_sop,
    input  wire logic                         dout_eop,
    output logic                              dout_ready,
    // Pacing: high stalls three cycles in four
    input  wire logic                         slow
);
    logic [1:0]                   pace;
    logic [lvmix_pkg::DATA_W+1:0] got_q [$];

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pace <= 2'h0;
        end else begin
            pace <= pace + 2'h1;
        end
    end

    assign dout_ready = nrst && (!slow || pace == 2'h0);

    // Ready is settled mid-cycle, so this sees what the next edge takes
    always @(negedge clk) begin
        if (nrst && dout_valid && dout_ready) begin
            got_q.push_back({dout_sop, dout_eop, dout_data});
        end
    end
endmodule

// File: sim/lvmix_top_test.sv
// Self-checking bench for the layered video mixer
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
    $display("ERROR t=%0t got %h exp %h", $time, g, e); end end
module lvmix_top_test;
    localparam int DW = lvmix_pkg::DATA_W;
    logic          clk, nrst, slow;
    logic [DW-1:0] din_data [lvmix_pkg::LAYERS];
    logic [7:0]    alpha_data [lvmix_pkg::LAYERS];
    logic [7:0]    bg_a;
    logic [2:0]    din_valid, din_ready, din_sop, din_eop;
    logic [2:0]    alpha_valid, alpha_ready, alpha_sop, alpha_eop;
    logic [DW-1:0] dout_data;
    logic          dout_valid, dout_ready, dout_sop, dout_eop;
    logic          ctrl_select, ctrl_wr_strobe;
    logic [3:0]    ctrl_word_offset;
    logic [31:0]   ctrl_wr_word, ctrl_rd_word;
    int            n_fail, checks_done, cyc;

    lvmix_top #(.ALPHA_EN(1'b1)) dut (.clk(clk), .nrst(nrst), .din_data(din_data), .din_valid(din_valid),
        .din_ready(din_ready), .din_sop(din_sop), .din_eop(din_eop), .alpha_data(alpha_data),
        .alpha_valid(alpha_valid), .alpha_ready(alpha_ready), .alpha_sop(alpha_sop), .alpha_eop(alpha_eop),
        .dout_data(dout_data), .dout_valid(dout_valid), .dout_ready(dout_ready), .dout_sop(dout_sop),
        .dout_eop(dout_eop), .ctrl_select(ctrl_select), .ctrl_word_offset(ctrl_word_offset),
        .ctrl_wr_strobe(ctrl_wr_strobe), .ctrl_wr_word(ctrl_wr_word), .ctrl_rd_word(ctrl_rd_word));
    lvmix_sink_model sink (.clk(clk), .nrst(nrst), .dout_data(dout_data), .dout_valid(dout_valid),
        .dout_sop(dout_sop), .dout_eop(dout_eop), .dout_ready(dout_ready), .slow(slow));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Hang guard: the whole run needs well under a thousand cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            give_verdict();
        end
    end

    task automatic ctrl(input logic wr, input logic sel, input logic [3:0] ofs, input logic [31:0] wd);
        @(posedge clk);
        ctrl_select      <= sel;
        ctrl_wr_strobe   <= wr;
        ctrl_word_offset <= ofs;
        ctrl_wr_word     <= wd;
        @(posedge clk);
        ctrl_select <= 1'b0;
        @(negedge clk);
    endtask

    task automatic rd_chk(input logic [3:0] ofs, input logic [31:0] e);
        ctrl(1'b0, 1'b1, ofs, 32'h0000_0000);
        `CHK(ctrl_rd_word, e)
    endtask

    // Presents word k on every layer and alpha lane; each lane is dropped once taken
    task automatic send(input logic [3*DW-1:0] px, input logic [15:0] al, input logic sop, input logic eop);
        logic [5:0] left;
        left = 6'h3F;
        @(posedge clk);
        for (int i = 0; i < 3; i++) begin
            din_data[i] <= px[i*DW +: DW];
        end
        alpha_data[0] <= bg_a;
        alpha_data[1] <= al[7:0];
        alpha_data[2] <= al[15:8];
        {din_sop, alpha_sop} <= {6{sop}};
        {din_eop, alpha_eop} <= {6{eop}};
        {alpha_valid, din_valid} <= left;
        for (int n = 0; n < 40 && left != 6'h00; n++) begin
            @(negedge clk);
            left = left & ~{alpha_ready, din_ready};
            @(posedge clk);
            {alpha_valid, din_valid} <= left;
        end
    endtask

    function automatic logic [DW-1:0] blend(input logic [DW-1:0] b, input logic [DW-1:0] t, input logic [7:0] a);
        logic [15:0] s;
        logic [DW-1:0] r;
        for (int c = 0; c < 3; c++) begin
            s = 16'(a) * 16'(t[c*8 +: 8]) + 16'(8'hFF - a) * 16'(b[c*8 +: 8]);
            r[c*8 +: 8] = s[15:8];
        end
        return r;
    endfunction

    task automatic out_chk(input logic sop, input logic eop, input logic [DW-1:0] d);
        logic [DW+1:0] w;
        for (int n = 0; n < 60 && sink.got_q.size() == 0; n++) begin
            @(negedge clk);
        end
        `CHK(sink.got_q.size() > 0, 1'b1)
        if (sink.got_q.size() > 0) begin
            w = sink.got_q.pop_front();
            `CHK(w, {sop, eop, d})
        end
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_regs();
        rd_chk(4'h2, 32'h0000_0007);
        rd_chk(4'h4, lvmix_pkg::IDENT_VALUE);
        rd_chk(4'h1, 32'h0000_0000);
        rd_chk(4'hF, 32'h0000_0000);
        ctrl(1'b1, 1'b0, 4'h0, 32'h0000_0001);
        rd_chk(4'h0, 32'h0000_0000);
        ctrl(1'b1, 1'b1, 4'h0, 32'h0000_0001);
        rd_chk(4'h0, 32'h0000_0001);
        ctrl(1'b1, 1'b1, 4'h2, 32'h0000_0001);
        rd_chk(4'h2, 32'h0000_0001);
    endtask

    task automatic t_background();
        slow <= 1'b1;
        send({24'hEEEEEE, 24'hDDDDDD, 24'h102030}, 16'hFFFF, 1'b1, 1'b0);
        send({24'hEEEEEE, 24'hDDDDDD, 24'h405060}, 16'hFFFF, 1'b0, 1'b0);
        send({24'hEEEEEE, 24'hDDDDDD, 24'h708090}, 16'hFFFF, 1'b0, 1'b1);
        out_chk(1'b1, 1'b0, 24'h102030);
        out_chk(1'b0, 1'b0, 24'h405060);
        out_chk(1'b0, 1'b1, 24'h708090);
        rd_chk(4'h3, 32'h0000_0001);
    endtask

    task automatic t_blend();
        slow <= 1'b0;
        ctrl(1'b1, 1'b1, 4'h2, 32'h0000_0007);
        send({24'h00FF80, 24'hFF0040, 24'h204060}, 16'hC040, 1'b1, 1'b0);
        send({24'h123456, 24'hABCDEF, 24'h000000}, 16'h00FF, 1'b0, 1'b1);
        out_chk(1'b1, 1'b0, blend(blend(24'h204060, 24'hFF0040, 8'h40), 24'h00FF80, 8'hC0));
        out_chk(1'b0, 1'b1, blend(blend(24'h000000, 24'hABCDEF, 8'hFF), 24'h123456, 8'h00));
    endtask

    task automatic t_nosop();
        ctrl(1'b1, 1'b1, 4'h2, 32'h0000_0001);
        bg_a = 8'h00;
        send({24'h111111, 24'h111111, 24'h0BAD00}, 16'h0000, 1'b0, 1'b0);
        send({24'h222222, 24'h222222, 24'h00600D}, 16'h0000, 1'b1, 1'b1);
        out_chk(1'b1, 1'b1, 24'h00600D);
        repeat (10) @(negedge clk);
        `CHK(sink.got_q.size(), 0)
        rd_chk(4'h3, 32'h0000_0003);
    endtask

    task automatic t_async_reset();
        @(negedge clk);
        `CHK(din_ready, 3'h7)
        #3 nrst = 1'b0;
        #1;
        `CHK({din_ready, dout_valid, ctrl_rd_word}, 36'h0)
        @(posedge clk);
        nrst <= 1'b1;
        @(negedge clk);
        @(negedge clk);
        `CHK(alpha_ready, 3'h7)
    endtask

    initial begin
        nrst = 1'b0;
        slow = 1'b0;
        n_fail = 0;
        checks_done = 0;
        cyc = 0;
        din_data = '{default: 24'h000000};
        alpha_data = '{default: 8'h00};
        bg_a = 8'h5A;
        {din_valid, din_sop, din_eop, alpha_valid, alpha_sop, alpha_eop} = 18'h0;
        {ctrl_select, ctrl_wr_strobe, ctrl_word_offset, ctrl_wr_word} = 38'h0;
        repeat (8) @(posedge clk);
        `CHK({din_ready, alpha_ready, dout_valid}, 7'h00)
        nrst <= 1'b1;
        repeat (2) @(posedge clk);
        @(negedge clk);
        `CHK(din_ready, 3'h7)
        t_regs();
        t_background();
        t_blend();
        t_nosop();
        t_async_reset();
        give_verdict();
    end
endmodule
